// [hwr_consts.vh]
// Constants for the halt, wake-up and reset sequencer.
// Assumes inclusion by bare name from the design files in the same folder.
`ifndef HWR_CONSTS_VH
`define HWR_CONSTS_VH

// ---------------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ---------------------------------------------------------------------------
`define HWR_OFS_RTC_CTRL     8'h00
`define HWR_OFS_STATUS       8'h04
`define HWR_OFS_WAKE_EN      8'h08
`define HWR_OFS_CMD          8'h0C

// ---------------------------------------------------------------------------
// Fields
// ---------------------------------------------------------------------------
`define HWR_RTC_SEL_LSB      0
`define HWR_RTC_SEL_MSB      2
`define HWR_RTC_IE_BIT       3
`define HWR_RTC_T0SRC_BIT    4
`define HWR_ST_PDF_BIT       0
`define HWR_ST_TO_BIT        1
`define HWR_ST_RTF_BIT       2
`define HWR_ST_HALT_BIT      3
`define HWR_ST_SST_BIT       4
`define HWR_CMD_RTF_CLR_BIT  0

// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define HWR_RTC_CTRL_RST     5'h07
`define HWR_WAKE_EN_RST      8'h00
`define HWR_RTC_BASE_EXP     8
`define HWR_SST_CYCLES       1024
`define HWR_OPT_LOAD_CYCLES  16
`define HWR_RESP_OKAY        2'h0
`define HWR_RESP_SLVERR      2'h2

`endif

// [hwr_rtc_div.v]
// RTC time-out divider: a free counter with a selectable tap.
// Assumes tick_i is a one-cycle pulse from RTC oscillator logic on clk_sys_i.
`timescale 1ns/100ps
`include "hwr_consts.vh"

module hwr_rtc_div #(
  parameter CNT_W = 15
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       tick_i,
  input  wire [2:0] sel_i,
  output reg        timeout_o
);

  reg [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] cnt_nxt;
  wire [CNT_W-1:0] mask;

  assign cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
  // Code 0 divides by 2^8; each step doubles, code 7 gives 2^15.
  assign mask = (({{(CNT_W-1){1'b0}}, 1'b1}) << (`HWR_RTC_BASE_EXP + sel_i))
                - {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r     <= {CNT_W{1'b0}};
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (tick_i) begin
        cnt_r <= cnt_nxt;
        if ((cnt_nxt & mask) == {CNT_W{1'b0}})
          timeout_o <= 1'b1;
      end
    end
  end

endmodule

// [hwr_seq.v]
// Halt, wake-up and reset sequencer with RTC time-out and AXI4-Lite registers.
// Assumes a core on clk_sys_i that issues halt and watchdog-clear pulses,
// and asynchronous pins for the external reset and port A wake-up.
// Functional notes
// - Three-bit code picks RTC divisor 2^8 up to 2^15.
// - Each RTC time-out sets the RTC interrupt request flag.
// - Enabled RTC time-out with stack not full calls vector 18H.
// - RTC time-out is offered as a clock source for timer 0.
// - Power-down stops the system clock; RTC or watchdog oscillator runs.
// - Power-down keeps memory, registers and port states.
// - Halt clears and restarts watchdog when on own or RTC oscillator.
// - Halt sets the power-down flag and clears the time-out flag.
// - Display timing keeps running in power-down on the slow oscillator.
// - Wake on reset pin, interrupt, port A fall or watchdog overflow.
// - Power-down flag clears at power-up and on watchdog-clear instruction.
// - Watchdog wake resets only program counter and stack pointer.
// - Each port A pin is enabled separately; wake resumes after halt.
// - Disabled interrupt or full stack resumes at next instruction.
// - A flag set before halt cannot wake the device.
// - Wait 1024 system clocks after a watchdog, interrupt or port A wake before resuming.
// - Time-out and power-down flags encode the reset cause.
// - Full chip reset on reset pin or normal watchdog time-out.
// - Chip reset loads defaults: PC zero, interrupts off, ports input.
// - Reset and power-on add an option load delay.
// - Normal watchdog overflow chip-resets and sets the time-out flag.
`timescale 1ns/100ps
`include "hwr_consts.vh"

module hwr_seq #(
  parameter PA_W       = 8,
  parameter SST_CYC    = `HWR_SST_CYCLES,
  parameter OPT_CYC    = `HWR_OPT_LOAD_CYCLES
) (
  input  wire            clk_sys_i,
  input  wire            rst_i,
  input  wire            ext_reset_pin_n_i,
  input  wire [PA_W-1:0] port_a_i,
  input  wire            halt_instr_i,
  input  wire            watchdog_clear_instr_i,
  input  wire            wdt_overflow_i,
  input  wire            wdt_on_slow_osc_i,
  input  wire            slow_osc_sel_i,
  input  wire            irq_pending_i,
  input  wire            irq_enabled_i,
  input  wire            stack_full_i,
  input  wire            rtc_tick_i,
  input  wire [31:0]     s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [31:0]     s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  output reg             sys_clk_en_o,
  output wire            slow_osc_run_o,
  output wire            lcd_clk_run_o,
  output reg             hold_state_o,
  output reg             chip_reset_o,
  output reg             warm_reset_o,
  output reg             wdt_clear_o,
  output reg             resume_next_o,
  output reg             irq_call_o,
  output wire            rtc_irq_call_o,
  output wire            rtc_t0_clk_o,
  output reg             powerdown_flag_o,
  output reg             timeout_flag_o
);

  // -------------------------------------------------------------------------
  // States
  // -------------------------------------------------------------------------
  localparam [2:0] ST_OPTLD = 3'h0;
  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_HALT  = 3'h2;
  localparam [2:0] ST_SST   = 3'h3;

  localparam W_NONE = 2'h0;
  localparam W_PORT = 2'h1;
  localparam W_IRQ  = 2'h2;
  localparam W_WDT  = 2'h3;

  localparam [10:0] SST_LAST = SST_CYC - 1;
  localparam [10:0] OPT_LAST = OPT_CYC - 1;

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  reg [2:0]      rst_pin_s_r;
  reg [PA_W-1:0] pa_s1_r;
  reg [PA_W-1:0] pa_s2_r;
  reg [PA_W-1:0] pa_s3_r;
  reg            rst_pin_low_r;
  reg [PA_W-1:0] pa_stable_r;

  // A change is accepted only when the second and third stages agree.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_pin_s_r   <= 3'h7;
      pa_s1_r       <= {PA_W{1'b1}};
      pa_s2_r       <= {PA_W{1'b1}};
      pa_s3_r       <= {PA_W{1'b1}};
      rst_pin_low_r <= 1'b0;
      pa_stable_r   <= {PA_W{1'b1}};
    end else begin
      rst_pin_s_r <= {rst_pin_s_r[1:0], ext_reset_pin_n_i};
      pa_s1_r     <= port_a_i;
      pa_s2_r     <= pa_s1_r;
      pa_s3_r     <= pa_s2_r;
      if (rst_pin_s_r[1] == rst_pin_s_r[2])
        rst_pin_low_r <= ~rst_pin_s_r[2];
      pa_stable_r <= (pa_s2_r & pa_s3_r) | (pa_stable_r & (pa_s2_r | pa_s3_r));
    end
  end

  wire [PA_W-1:0] pa_agree_val;
  assign pa_agree_val = (pa_s2_r & pa_s3_r) | (pa_stable_r & (pa_s2_r | pa_s3_r));

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  reg [2:0]      rtc_sel_r;
  reg            rtc_ie_r;
  reg            rtc_t0src_r;
  reg [PA_W-1:0] wake_en_r;
  reg            rtc_irq_flag_r;
  reg [2:0]      state_r;
  reg [10:0]     cnt_r;
  reg [1:0]      wake_src_r;
  reg            irq_block_r;

  wire rtc_timeout;
  wire rtc_flag_clr;

  hwr_rtc_div #(
    .CNT_W     (15)
  ) u_rtc_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (rtc_tick_i),
    .sel_i     (rtc_sel_r),
    .timeout_o (rtc_timeout)
  );

  assign rtc_t0_clk_o   = rtc_t0src_r & rtc_timeout;
  assign rtc_irq_call_o = rtc_irq_flag_r & rtc_ie_r & ~stack_full_i &
                          (state_r == ST_RUN);
  assign slow_osc_run_o = slow_osc_sel_i;
  assign lcd_clk_run_o  = sys_clk_en_o | slow_osc_sel_i;

  // -------------------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------------------
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_go;
  assign wr_go = aw_hold_r & w_hold_r;
  assign rtc_flag_clr = wr_go && (aw_addr_r == `HWR_OFS_CMD) && w_strb_r[0] &&
                        w_data_r[`HWR_CMD_RTF_CLR_BIT];

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `HWR_OFS_RTC_CTRL) || (a == `HWR_OFS_STATUS) ||
                (a == `HWR_OFS_WAKE_EN) || (a == `HWR_OFS_CMD);
    end
  endfunction

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HWR_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `HWR_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      {rtc_t0src_r, rtc_ie_r, rtc_sel_r} <= `HWR_RTC_CTRL_RST;
      wake_en_r    <= `HWR_WAKE_EN_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok(aw_addr_r) ? `HWR_RESP_OKAY : `HWR_RESP_SLVERR;
        // Software should keep codes at 4 and above; low codes are still honoured.
        if (aw_addr_r == `HWR_OFS_RTC_CTRL && w_strb_r[0]) begin
          rtc_sel_r   <= w_data_r[`HWR_RTC_SEL_MSB:`HWR_RTC_SEL_LSB];
          rtc_ie_r    <= w_data_r[`HWR_RTC_IE_BIT];
          rtc_t0src_r <= w_data_r[`HWR_RTC_T0SRC_BIT];
        end
        if (aw_addr_r == `HWR_OFS_WAKE_EN && w_strb_r[0])
          wake_en_r <= w_data_r[PA_W-1:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_ok(s_axi_araddr[7:0]) ? `HWR_RESP_OKAY : `HWR_RESP_SLVERR;
        case (s_axi_araddr[7:0])
          `HWR_OFS_RTC_CTRL:
            s_axi_rdata <= {27'h0000000, rtc_t0src_r, rtc_ie_r, rtc_sel_r};
          `HWR_OFS_STATUS:
            s_axi_rdata <= {27'h0000000, state_r == ST_SST, state_r == ST_HALT,
                            rtc_irq_flag_r, timeout_flag_o, powerdown_flag_o};
          `HWR_OFS_WAKE_EN:
            s_axi_rdata <= {{(32-PA_W){1'b0}}, wake_en_r};
          default:
            s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (chip_reset_o) {rtc_t0src_r, rtc_ie_r, rtc_sel_r} <= `HWR_RTC_CTRL_RST;
    end
  end

  // -------------------------------------------------------------------------
  // RTC interrupt request flag: a time-out wins over a clear.
  // -------------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rst_i)
      rtc_irq_flag_r <= 1'b0;
    else if (rtc_timeout)
      rtc_irq_flag_r <= 1'b1;
    else if (rtc_flag_clr)
      rtc_irq_flag_r <= 1'b0;
  end

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  wire [PA_W-1:0] pa_fall;
  wire            irq_wake;
  assign pa_fall  = pa_stable_r & ~pa_agree_val & wake_en_r;
  // A request already pending at halt is masked until it drops.
  assign irq_wake = irq_pending_i & ~irq_block_r;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r          <= ST_OPTLD;
      cnt_r            <= 11'h000;
      wake_src_r       <= W_NONE;
      irq_block_r      <= 1'b0;
      sys_clk_en_o     <= 1'b0;
      hold_state_o     <= 1'b1;
      chip_reset_o     <= 1'b1;
      warm_reset_o     <= 1'b0;
      wdt_clear_o      <= 1'b0;
      resume_next_o    <= 1'b0;
      irq_call_o       <= 1'b0;
      powerdown_flag_o <= 1'b0;
      timeout_flag_o   <= 1'b0;
    end else begin
      wdt_clear_o   <= 1'b0;
      warm_reset_o  <= 1'b0;
      resume_next_o <= 1'b0;
      irq_call_o    <= 1'b0;
      chip_reset_o  <= 1'b0;
      if (rst_pin_low_r) begin
        // Chip reset from the pin; a pin wake from halt reports 01.
        if (state_r == ST_HALT) begin
          timeout_flag_o   <= 1'b0;
          powerdown_flag_o <= 1'b1;
        end
        chip_reset_o <= 1'b1;
        wdt_clear_o  <= 1'b1;
        sys_clk_en_o <= 1'b0;
        hold_state_o <= 1'b1;
        cnt_r        <= 11'h000;
        state_r      <= ST_OPTLD;
      end else begin
        case (state_r)
          ST_OPTLD: begin
            chip_reset_o <= 1'b1;
            if (cnt_r == OPT_LAST) begin
              cnt_r        <= 11'h000;
              sys_clk_en_o <= 1'b1;
              hold_state_o <= 1'b0;
              state_r      <= ST_RUN;
            end else begin
              cnt_r <= cnt_r + 11'h001;
            end
          end
          ST_RUN: begin
            if (wdt_overflow_i) begin
              timeout_flag_o <= 1'b1;
              chip_reset_o   <= 1'b1;
              wdt_clear_o    <= 1'b1;
              sys_clk_en_o   <= 1'b0;
              hold_state_o   <= 1'b1;
              cnt_r          <= 11'h000;
              state_r        <= ST_OPTLD;
            end else if (halt_instr_i) begin
              powerdown_flag_o <= 1'b1;
              timeout_flag_o   <= 1'b0;
              wdt_clear_o      <= wdt_on_slow_osc_i;
              irq_block_r      <= irq_pending_i;
              sys_clk_en_o     <= 1'b0;
              hold_state_o     <= 1'b1;
              state_r          <= ST_HALT;
            end else if (watchdog_clear_instr_i) begin
              powerdown_flag_o <= 1'b0;
            end
          end
          ST_HALT: begin
            if (!irq_pending_i)
              irq_block_r <= 1'b0;
            if (wdt_overflow_i) begin
              timeout_flag_o   <= 1'b1;
              powerdown_flag_o <= 1'b1;
              wake_src_r       <= W_WDT;
              state_r          <= ST_SST;
            end else if (irq_wake) begin
              wake_src_r <= W_IRQ;
              state_r    <= ST_SST;
            end else if (pa_fall != {PA_W{1'b0}}) begin
              wake_src_r <= W_PORT;
              state_r    <= ST_SST;
            end
            cnt_r <= 11'h000;
          end
          ST_SST: begin
            if (cnt_r == SST_LAST) begin
              cnt_r        <= 11'h000;
              sys_clk_en_o <= 1'b1;
              hold_state_o <= 1'b0;
              state_r      <= ST_RUN;
              case (wake_src_r)
                W_WDT:   warm_reset_o  <= 1'b1;
                W_IRQ:   begin
                  irq_call_o    <= irq_enabled_i & ~stack_full_i;
                  resume_next_o <= ~(irq_enabled_i & ~stack_full_i);
                end
                W_PORT:  resume_next_o <= 1'b1;
                default: resume_next_o <= 1'b1;
              endcase
            end else begin
              cnt_r <= cnt_r + 11'h001;
            end
          end
          default: begin
            state_r <= ST_OPTLD;
            cnt_r   <= 11'h000;
          end
        endcase
      end
    end
  end

endmodule

// [hwr_core_model.sv]
// Core-side partner of the sequencer: issues halt and watchdog-clear pulses and RTC ticks.
// Assumes the bench asks for instructions; the model issues them only while clocked.
`timescale 1ns/100ps
module hwr_core_model (
  input  wire clk_sys_i,
  input  wire run_i,
  input  wire halt_req_i,
  input  wire clr_req_i,
  input  wire tick_en_i,
  output wire halt_o,
  output wire clr_o,
  output reg  tick_o = 1'b0
);
  // A core whose clock is gated cannot execute, so requests are dropped then.
  assign halt_o = halt_req_i & run_i;
  assign clr_o  = clr_req_i & run_i;
  always @(posedge clk_sys_i) begin
    tick_o <= tick_en_i;
  end
endmodule

// [hwr_seq_props.sv]
// Concurrent checks on the ports of the halt, wake-up and reset sequencer.
// Assumes it is bound into hwr_seq; every check runs on clk_sys_i and pauses in reset.
`timescale 1ns/100ps
module hwr_seq_props #(
  parameter PA_W    = 8,
  parameter SST_CYC = 1024,
  parameter OPT_CYC = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ext_reset_pin_n_i,
  input wire halt_instr_i,
  input wire watchdog_clear_instr_i,
  input wire wdt_overflow_i,
  input wire slow_osc_sel_i,
  input wire stack_full_i,
  input wire sys_clk_en_o,
  input wire slow_osc_run_o,
  input wire lcd_clk_run_o,
  input wire hold_state_o,
  input wire chip_reset_o,
  input wire warm_reset_o,
  input wire resume_next_o,
  input wire irq_call_o,
  input wire rtc_irq_call_o,
  input wire powerdown_flag_o,
  input wire timeout_flag_o
);
  // Counts consecutive cycles with the core clock off, so a resume can be tied to the delay.
  reg  [15:0] stop_cnt_r = 16'h0;
  wire        resumed = resume_next_o | irq_call_o | warm_reset_o;
  always @(posedge clk_sys_i) begin
    stop_cnt_r <= sys_clk_en_o ? 16'h0 : stop_cnt_r + {15'h0, stop_cnt_r != 16'hFFFF};
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_halt_flags: assert property (
    halt_instr_i && sys_clk_en_o && !chip_reset_o && !wdt_overflow_i && ext_reset_pin_n_i
    |=> powerdown_flag_o && !timeout_flag_o) else $error("halt left the flags wrong");
  a_halt_stops: assert property (
    halt_instr_i && sys_clk_en_o && !chip_reset_o && !wdt_overflow_i && ext_reset_pin_n_i
    |=> !sys_clk_en_o && hold_state_o) else $error("halt did not stop the core");
  a_stop_hold: assert property (
    !sys_clk_en_o |-> hold_state_o) else $error("core clock off without state hold");
  a_clr_pdf: assert property (
    watchdog_clear_instr_i && sys_clk_en_o && !halt_instr_i && !wdt_overflow_i
    |=> !powerdown_flag_o) else $error("watchdog clear kept the power-down flag");
  a_wdt_run: assert property (
    wdt_overflow_i && sys_clk_en_o |-> ##[1:2] (chip_reset_o && timeout_flag_o))
    else $error("watchdog overflow in run did not reset");
  a_warm_flags: assert property (
    warm_reset_o |-> powerdown_flag_o && timeout_flag_o && !chip_reset_o)
    else $error("warm reset with wrong flags or full reset");
  a_sst_wait: assert property (
    resumed |-> sys_clk_en_o && stop_cnt_r >= SST_CYC) else $error("resumed too early");
  a_pulse_once: assert property (
    resumed |=> !resumed) else $error("resume pulse longer than one cycle");
  a_rtc_call: assert property (
    rtc_irq_call_o |-> !stack_full_i && sys_clk_en_o) else $error("RTC call with stack full");
  a_osc_follow: assert property (
    slow_osc_run_o == slow_osc_sel_i && lcd_clk_run_o == (sys_clk_en_o | slow_osc_sel_i))
    else $error("slow oscillator or display run wrong");
  a_por_flags: assert property (
    $fell(rst_i) |-> chip_reset_o && !sys_clk_en_o && !powerdown_flag_o && !timeout_flag_o)
    else $error("power-on state wrong");
  a_opt_hold: assert property (
    $fell(rst_i) |-> chip_reset_o [*8]) else $error("option load too short");
  a_pin_reset: assert property (
    !ext_reset_pin_n_i [*4] |-> ##[0:3] chip_reset_o) else $error("reset pin ignored");
endmodule

bind hwr_seq hwr_seq_props #(.PA_W(PA_W), .SST_CYC(SST_CYC), .OPT_CYC(OPT_CYC)) u_props (.*);

// [halt_wake_reset_rtc_test.sv]
// Self-checking bench for the halt, wake-up and reset sequencer.
// Assumes hwr_seq, its bound checker and the core model are compiled alongside.
`timescale 1ns/100ps
`include "hwr_consts.vh"
module halt_wake_reset_rtc_test;
  localparam int         STARTUP_DELAY_TIMER = 1024;
  localparam int         OPT = 16;
  localparam logic [1:0] OK  = `HWR_RESP_OKAY;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, ext_reset_pin_n_i = 1'b1;
  logic        wdt_overflow_i = 1'b0, wdt_on_slow_osc_i = 1'b0, slow_osc_sel_i = 1'b0;
  logic        irq_pending_i = 1'b0, irq_enabled_i = 1'b0, stack_full_i = 1'b0;
  logic        halt_req = 1'b0, clr_req = 1'b0, tick_en = 1'b1;
  logic [7:0]  port_a_i = 8'hFF;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         sys_clk_en_o, slow_osc_run_o, lcd_clk_run_o, hold_state_o, chip_reset_o;
  wire         warm_reset_o, wdt_clear_o, resume_next_o, irq_call_o, rtc_irq_call_o;
  wire         rtc_t0_clk_o, powerdown_flag_o, timeout_flag_o;
  wire         halt_instr_i, watchdog_clear_instr_i, rtc_tick_i;
  int          fail_count = 0, checks = 0, wclr_cnt = 0, n, j, c0;
  integer      seed = 32'h73821F92;
  logic [31:0] d, w;

  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (wdt_clear_o === 1'b1) wclr_cnt++;

  hwr_seq #(.PA_W(8), .SST_CYC(STARTUP_DELAY_TIMER), .OPT_CYC(OPT)) u_dut (.*);
  hwr_core_model u_core (.clk_sys_i(clk_sys_i), .run_i(sys_clk_en_o), .halt_req_i(halt_req),
    .clr_req_i(clr_req), .tick_en_i(tick_en), .halt_o(halt_instr_i),
    .clr_o(watchdog_clear_instr_i), .tick_o(rtc_tick_i));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic chk_cyc(input int k, input int lo, input int hi);
    checks++;
    if (k < lo || k > hi) begin
      fail_count++;
      $display("[FAIL] %0t took %0d cycles, expected %0d to %0d", $time, k, lo, hi);
    end
  endtask

  function automatic int rtc_div(input int code);
    return 1 << (`HWR_RTC_BASE_EXP + code);
  endfunction

  function automatic logic pick(input int k);
    case (k)
      0: pick = resume_next_o;
      1: pick = irq_call_o;
      2: pick = warm_reset_o;
      3: pick = rtc_t0_clk_o;
      4: pick = sys_clk_en_o;
      default: pick = chip_reset_o;
    endcase
  endfunction

  // Waits edge by edge until the chosen output is high; gives up after 40000 edges if it never rises.
  task automatic waitk(input int k, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
    end while (pick(k) !== 1'b1 && cnt < 40000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk_sys_i);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, OK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int k;
    @(posedge clk_sys_i);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask

  task automatic do_halt;
    @(posedge clk_sys_i);
    halt_req <= 1'b1;
    @(posedge clk_sys_i);
    halt_req <= 1'b0;
    #1;
    chk({timeout_flag_o, powerdown_flag_o}, 2'b01);
    chk({sys_clk_en_o, hold_state_o}, 2'b01);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    waitk(4, n);
    chk_cyc(n, OPT, OPT + 3);
    chk({timeout_flag_o, powerdown_flag_o}, 2'b00);
    rd(`HWR_OFS_RTC_CTRL, OK, d);
    chk(d, 32'h7);
    rd(`HWR_OFS_WAKE_EN, OK, d);
    chk(d, 32'h0);
    rd(`HWR_OFS_CMD, OK, d);
    chk(d, 32'h0);
    rd(8'h10, `HWR_RESP_SLVERR, d);
    chk(d, 32'h0);
    // Codes 0 to 3 are outside the advised range and are set here only to time the tap.
    for (int c = 0; c < 8; c++) begin
      wr(`HWR_OFS_RTC_CTRL, 32'h10 | c);
      if (c < 6) begin
        waitk(3, n);
        waitk(3, n);
        chk_cyc(n, rtc_div(c), rtc_div(c));
      end
    end
    rd(`HWR_OFS_STATUS, OK, d);
    chk(d[2], 1'b1);
    wr(`HWR_OFS_CMD, 32'h1);
    rd(`HWR_OFS_STATUS, OK, d);
    chk(d[2], 1'b0);
    @(posedge clk_sys_i);
    stack_full_i <= 1'b1;
    wr(`HWR_OFS_RTC_CTRL, 32'h8);
    repeat (300) @(posedge clk_sys_i);
    #1 chk(rtc_irq_call_o, 1'b0);
    @(posedge clk_sys_i);
    stack_full_i <= 1'b0;
    #1 chk(rtc_irq_call_o, 1'b1);
    wr(`HWR_OFS_RTC_CTRL, 32'h7);
    wr(`HWR_OFS_CMD, 32'h1);
    j = {$random(seed)} % 7;
    w = ({$random(seed)} & 32'h7F) | (32'h1 << j);
    wr(`HWR_OFS_WAKE_EN, w);
    rd(`HWR_OFS_WAKE_EN, OK, d);
    chk(d, w);
    d = $random(seed);
    @(posedge clk_sys_i);
    wdt_on_slow_osc_i <= 1'b1;
    slow_osc_sel_i <= d[0];
    c0 = wclr_cnt;
    do_halt();
    repeat (3) @(posedge clk_sys_i);
    #1 chk(wclr_cnt > c0, 1'b1);
    @(posedge clk_sys_i);
    port_a_i <= 8'h7F;
    repeat (20) @(posedge clk_sys_i);
    #1 chk(sys_clk_en_o, 1'b0);
    @(posedge clk_sys_i);
    port_a_i <= 8'h7F & ~(8'h1 << j);
    waitk(0, n);
    chk_cyc(n, STARTUP_DELAY_TIMER, STARTUP_DELAY_TIMER + 8);
    @(posedge clk_sys_i);
    port_a_i <= 8'hFF;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys_i);
      irq_enabled_i <= (m != 1);
      stack_full_i <= (m == 2);
      do_halt();
      @(posedge clk_sys_i);
      irq_pending_i <= 1'b1;
      waitk(m == 0 ? 1 : 0, n);
      chk_cyc(n, STARTUP_DELAY_TIMER, STARTUP_DELAY_TIMER + 8);
      @(posedge clk_sys_i);
      irq_pending_i <= 1'b0;
    end
    @(posedge clk_sys_i);
    irq_pending_i <= 1'b1;
    do_halt();
    repeat (STARTUP_DELAY_TIMER + 50) @(posedge clk_sys_i);
    #1 chk(sys_clk_en_o, 1'b0);
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b0;
    waitk(2, n);
    chk_cyc(n, STARTUP_DELAY_TIMER, STARTUP_DELAY_TIMER + 8);
    chk({timeout_flag_o, powerdown_flag_o, chip_reset_o}, 3'b110);
    @(posedge clk_sys_i);
    irq_pending_i <= 1'b0;
    wr(`HWR_OFS_RTC_CTRL, 32'h1A);
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b0;
    waitk(5, n);
    chk({timeout_flag_o, powerdown_flag_o}, 2'b11);
    waitk(4, n);
    rd(`HWR_OFS_RTC_CTRL, OK, d);
    chk(d, 32'h7);
    @(posedge clk_sys_i);
    clr_req <= 1'b1;
    @(posedge clk_sys_i);
    clr_req <= 1'b0;
    #1 chk(powerdown_flag_o, 1'b0);
    @(posedge clk_sys_i);
    ext_reset_pin_n_i <= 1'b0;
    @(posedge clk_sys_i);
    ext_reset_pin_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1 chk(chip_reset_o, 1'b0);
    for (int h = 0; h < 2; h++) begin
      if (h == 1) do_halt();
      @(posedge clk_sys_i);
      ext_reset_pin_n_i <= 1'b0;
      waitk(5, n);
      chk_cyc(n, 1, 6);
      chk({timeout_flag_o, powerdown_flag_o}, h == 1 ? 2'b01 : 2'b10);
      @(posedge clk_sys_i);
      ext_reset_pin_n_i <= 1'b1;
      waitk(4, n);
    end
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    waitk(4, n);
    chk({timeout_flag_o, powerdown_flag_o}, 2'b00);
    complete_run();
  end

  // The run needs about 31000 cycles; this limit allows roughly three times that.
  initial begin
    #4000000;
    fail_count++;
    complete_run();
  end
endmodule
